// ### core/mis_top.sv
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
module mis_top
  import mis_pkg::*;
#(
  parameter int TICK_CYCLES = MIS_TICK_CYC
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        contact_closed,
  input  wire logic        pump_running,
  input  wire logic        fault_in,
  output logic             stop_request,
  output logic             alarm_event,
  output logic             shutdown_event,
  output logic             fault_clear,
  output logic             irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [4:0]  ctrl;
  logic [15:0] qual_dly;
  logic [15:0] start_dly;
  logic [15:0] detect_dly;
  logic [15:0] restart_dly;
  logic [2:0]  irq_st;
  logic [2:0]  irq_mask;
  logic        man_reset;
  logic        fault_seen;

  logic        pol;
  logic [1:0]  react;
  logic        rtype;
  logic        func;
  assign pol   = ctrl[MIS_CTRL_POL];
  assign react = ctrl[MIS_CTRL_REACT_HI:MIS_CTRL_REACT_LO];
  assign rtype = ctrl[MIS_CTRL_RTYPE];
  assign func  = ctrl[MIS_CTRL_FUNC];

  // ----------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ----------------------------------------------------------------
  logic       dp_wr;
  logic [7:0] dp_addr;
  logic       accept;
  assign accept = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr   <= 1'b0;
      dp_addr <= 8'h00;
    end else if (ce) begin
      dp_wr   <= accept && hwrite;
      dp_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // seconds time base
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt;
  logic        tick;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b0;
    end else if (ce) begin
      if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
        tick_cnt <= 32'h0000_0000;
        tick     <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 32'h0000_0001;
        tick     <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // input conditioning
  // ----------------------------------------------------------------
  logic raw_active;
  logic qualified;
  assign raw_active = (pol == MIS_POL_CLOSED) ? contact_closed : !contact_closed;

  mis_tmr_if q_if ();
  assign q_if.run   = raw_active;
  assign q_if.tick  = tick;
  assign q_if.limit = qual_dly;
  mis_sec_timer u_qual (.hclk(hclk), .hresetn(hresetn), .ce(ce), .t(q_if));
  assign qualified = q_if.done;

  // ----------------------------------------------------------------
  // start arming
  // ----------------------------------------------------------------
  mis_arm_e arm_st;
  mis_tmr_if s_if ();
  assign s_if.run   = (arm_st == MIS_ARMING) && pump_running;
  assign s_if.tick  = tick;
  assign s_if.limit = start_dly;
  mis_sec_timer u_start (.hclk(hclk), .hresetn(hresetn), .ce(ce), .t(s_if));

  // the delay counts main pump run time only; a stop before expiry re-arms
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arm_st <= MIS_IDLE;
    end else if (ce) begin
      case (arm_st)
        MIS_IDLE:   if (pump_running) arm_st <= MIS_ARMING;
        MIS_ARMING: begin
          if (!pump_running) arm_st <= MIS_IDLE;
          else if (s_if.done) arm_st <= MIS_WATCH;
        end
        MIS_WATCH:  if (!pump_running) arm_st <= MIS_IDLE;
        default:    arm_st <= MIS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // detection
  // ----------------------------------------------------------------
  logic evaluate;
  logic detected;
  assign evaluate = (arm_st == MIS_WATCH) && pump_running && (func == MIS_FUNC_GP)
                    && (react != MIS_REACT_DIS) && qualified;
  mis_tmr_if d_if ();
  assign d_if.run   = evaluate;
  assign d_if.tick  = tick;
  assign d_if.limit = detect_dly;
  mis_sec_timer u_det (.hclk(hclk), .hresetn(hresetn), .ce(ce), .t(d_if));
  assign detected = d_if.done;

  logic set_alarm;
  logic set_shut;
  assign set_alarm = detected && (react == MIS_REACT_ALARM) && !alarm_event;
  assign set_shut  = detected && (react == MIS_REACT_SHUT) && !shutdown_event;

  // ----------------------------------------------------------------
  // clearing sources
  // ----------------------------------------------------------------
  logic reset_in;
  logic restart_done;
  assign reset_in = (func == MIS_FUNC_RESET) && qualified;

  mis_tmr_if r_if ();
  assign r_if.run   = shutdown_event && (rtype != MIS_RTYPE_MAN);
  assign r_if.tick  = tick;
  assign r_if.limit = restart_dly;
  mis_sec_timer u_rst (.hclk(hclk), .hresetn(hresetn), .ce(ce), .t(r_if));
  assign restart_done = r_if.done;

  logic clr_shut;
  assign clr_shut = man_reset || restart_done || reset_in;

  // set wins over clear; alarm clears on a reset or by itself once detection ends
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shutdown_event <= 1'b0;
      stop_request   <= 1'b0;
    end else if (ce) begin
      if (set_shut) begin
        shutdown_event <= 1'b1;
        stop_request   <= 1'b1;
      end else if (clr_shut) begin
        shutdown_event <= 1'b0;
        stop_request   <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_event <= 1'b0;
    end else if (ce) begin
      if (set_alarm) alarm_event <= 1'b1;
      else if (man_reset || reset_in || !detected) alarm_event <= 1'b0;
    end
  end

  // fault clear is a level request to the fault owner while the reset input is active and fault_in is high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_clear <= 1'b0;
      fault_seen  <= 1'b0;
    end else if (ce) begin
      fault_seen  <= fault_in;
      fault_clear <= reset_in && fault_in;
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  logic wr_irq_st, wr_cmd;
  assign wr_irq_st = dp_wr && dp_addr == MIS_OFS_IRQ_ST;
  assign wr_cmd    = dp_wr && dp_addr == MIS_OFS_CMD;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl        <= MIS_CTRL_RST;
      qual_dly    <= MIS_QUAL_RST;
      start_dly   <= MIS_START_RST;
      detect_dly  <= MIS_DETECT_RST;
      restart_dly <= MIS_RESTART_RST;
      irq_mask    <= 3'h0;
    end else if (ce && dp_wr) begin
      case (dp_addr)
        MIS_OFS_CTRL:     ctrl        <= hwdata[4:0];
        MIS_OFS_QUAL:     qual_dly    <= hwdata[15:0];
        MIS_OFS_START:    start_dly   <= hwdata[15:0];
        MIS_OFS_DETECT:   detect_dly  <= hwdata[15:0];
        MIS_OFS_RESTART:  restart_dly <= hwdata[15:0];
        MIS_OFS_IRQ_MASK: irq_mask    <= hwdata[2:0];
        default: ;
      endcase
    end
  end

  // operator reset is a one-cycle pulse from a command write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      man_reset <= 1'b0;
    end else if (ce) begin
      man_reset <= wr_cmd && hwdata[MIS_CMD_RESET];
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  logic [2:0] irq_set;
  assign irq_set = {clr_shut && shutdown_event, set_shut, set_alarm};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_st <= 3'h0;
      irq    <= 1'b0;
    end else if (ce) begin
      irq_st <= irq_set | (irq_st & ~(wr_irq_st ? hwdata[2:0] : 3'h0));
      irq    <= |((irq_set | (irq_st & ~(wr_irq_st ? hwdata[2:0] : 3'h0))) & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      MIS_OFS_CTRL:     rd_mux = {27'h0, ctrl};
      MIS_OFS_QUAL:     rd_mux = {16'h0, qual_dly};
      MIS_OFS_START:    rd_mux = {16'h0, start_dly};
      MIS_OFS_DETECT:   rd_mux = {16'h0, detect_dly};
      MIS_OFS_RESTART:  rd_mux = {16'h0, restart_dly};
      MIS_OFS_STATUS:   rd_mux = {26'h0, fault_seen, stop_request, shutdown_event,
                                  alarm_event, arm_st == MIS_WATCH, qualified};
      MIS_OFS_IRQ_ST:   rd_mux = {29'h0, irq_st};
      MIS_OFS_IRQ_MASK: rd_mux = {29'h0, irq_mask};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  // read data registered when the address phase is taken, so it stands in the data phase
  // limitation: a read right behind a write sees the register as it was before that write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      hrdata <= (accept && !hwrite) ? rd_mux : 32'h0000_0000;
    end
  end

endmodule : mis_top

// ### core/mis_pkg.sv
package mis_pkg;

  // ----------------------------------------------------------------
  // bus
  // ----------------------------------------------------------------
  localparam int          MIS_AW           = 8;
  localparam logic [7:0]  MIS_OFS_CTRL     = 8'h00;
  localparam logic [7:0]  MIS_OFS_QUAL     = 8'h04;
  localparam logic [7:0]  MIS_OFS_START    = 8'h08;
  localparam logic [7:0]  MIS_OFS_DETECT   = 8'h0c;
  localparam logic [7:0]  MIS_OFS_RESTART  = 8'h10;
  localparam logic [7:0]  MIS_OFS_STATUS   = 8'h14;
  localparam logic [7:0]  MIS_OFS_IRQ_ST   = 8'h18;
  localparam logic [7:0]  MIS_OFS_IRQ_MASK = 8'h1c;
  localparam logic [7:0]  MIS_OFS_CMD      = 8'h20;

  // ----------------------------------------------------------------
  // ctrl fields
  // ----------------------------------------------------------------
  localparam int MIS_CTRL_POL      = 0;
  localparam int MIS_CTRL_REACT_LO = 1;
  localparam int MIS_CTRL_REACT_HI = 2;
  localparam int MIS_CTRL_RTYPE    = 3;
  localparam int MIS_CTRL_FUNC     = 4;
  localparam logic [4:0] MIS_CTRL_RST = 5'h00;

  // status / irq bit positions
  localparam int MIS_ST_ACTIVE   = 0;
  localparam int MIS_ST_ARMED    = 1;
  localparam int MIS_ST_ALARM    = 2;
  localparam int MIS_ST_SHUTDOWN = 3;
  localparam int MIS_ST_STOPREQ  = 4;
  localparam int MIS_ST_FAULT    = 5;
  localparam int MIS_IRQ_ALARM   = 0;
  localparam int MIS_IRQ_SHUT    = 1;
  localparam int MIS_IRQ_CLEAR   = 2;
  localparam int MIS_CMD_RESET   = 0;

  // delays in seconds, reset values
  localparam int          MIS_DW          = 16;
  localparam logic [15:0] MIS_QUAL_RST    = 16'h0000;
  localparam logic [15:0] MIS_START_RST   = 16'h0001;
  localparam logic [15:0] MIS_DETECT_RST  = 16'h0001;
  localparam logic [15:0] MIS_RESTART_RST = 16'h003c;

  // encodings (setting n/m minus one)
  localparam logic       MIS_POL_OPEN    = 1'b0;
  localparam logic       MIS_POL_CLOSED  = 1'b1;
  localparam logic [1:0] MIS_REACT_DIS   = 2'h0;
  localparam logic [1:0] MIS_REACT_ALARM = 2'h1;
  localparam logic [1:0] MIS_REACT_SHUT  = 2'h2;
  localparam logic       MIS_RTYPE_MAN   = 1'b0;
  localparam logic       MIS_FUNC_GP     = 1'b0;
  localparam logic       MIS_FUNC_RESET  = 1'b1;

  // time base
  localparam longint MIS_CLK_HZ  = 125000000;
  localparam longint MIS_TICK_S  = 1;
  localparam int     MIS_TICK_CYC = int'(MIS_CLK_HZ * MIS_TICK_S);

  typedef enum logic [1:0] {MIS_IDLE, MIS_ARMING, MIS_WATCH} mis_arm_e;

endpackage : mis_pkg

// ### core/mis_tmr_if.sv
`timescale 1ns/1ns
interface mis_tmr_if;
  logic        run;
  logic        tick;
  logic [15:0] limit;
  logic        done;
  modport owner (output run, output tick, output limit, input done);
  modport timer (input run, input tick, input limit, output done);
endinterface : mis_tmr_if

// ### core/mis_sec_timer.sv
`timescale 1ns/1ns
module mis_sec_timer
  import mis_pkg::*;
(
  input  wire logic   hclk,
  input  wire logic   hresetn,
  input  wire logic   ce,
  mis_tmr_if.timer    t
);
  logic [15:0] cnt;

  // restarts from zero whenever run drops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 16'h0000;
    end else if (ce) begin
      if (!t.run) begin
        cnt <= 16'h0000;
      end else if (t.tick && cnt < t.limit) begin
        cnt <= cnt + 16'h0001;
      end
    end
  end

  assign t.done = t.run && (cnt >= t.limit);
endmodule : mis_sec_timer

// ### verif/mis_chk.sv
`timescale 1ns/1ns
module mis_chk
  import mis_pkg::*;
#(
  parameter int TICK_CYCLES = 4
)(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  input  wire logic hreadyout,
  input  wire logic hresp,
  input  wire logic pump_running,
  input  wire logic fault_in,
  input  wire logic stop_request,
  input  wire logic alarm_event,
  input  wire logic shutdown_event,
  input  wire logic fault_clear
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_STOP_WITH_SHUT: assert property (stop_request == shutdown_event)
    else $error("stop request differs from shutdown");
  AST_ALARM_NEEDS_RUN: assert property ($rose(alarm_event) |-> $past(pump_running))
    else $error("alarm without running pump");
  AST_SHUT_NEEDS_RUN: assert property ($rose(shutdown_event) |-> $past(pump_running))
    else $error("shutdown without running pump");
  AST_ALARM_NO_STOP: assert property ($rose(alarm_event) && !shutdown_event |-> !stop_request)
    else $error("alarm stopped the pump");
  AST_FCLR_CAUSE: assert property (fault_clear |-> $past(fault_in))
    else $error("fault clear without fault");
  AST_SHUT_LATCH: assert property ($fell(pump_running) && shutdown_event |=> shutdown_event)
    else $error("shutdown lost on pump stop");
  // ce low must freeze the event state, not just the timers
  AST_CE_FREEZE: assert property (!ce |=> $stable(alarm_event) && $stable(shutdown_event))
    else $error("state moved with ce low");
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
endmodule : mis_chk

bind mis_top mis_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .hreadyout(hreadyout), .hresp(hresp),
  .pump_running(pump_running), .fault_in(fault_in), .stop_request(stop_request),
  .alarm_event(alarm_event), .shutdown_event(shutdown_event), .fault_clear(fault_clear));

// ### verif/mis_field.sv
`timescale 1ns/1ns
module mis_field (
  input  wire logic hclk,
  input  wire logic want_closed,
  input  wire logic chatter,
  output logic      contact_closed
);
  // a chattering contact flips every clock, worse than any real bounce
  initial contact_closed = 1'b0;
  always @(posedge hclk) begin
    contact_closed <= chatter ? !contact_closed : want_closed;
  end
endmodule : mis_field

// ### verif/mis_tb_top.sv
`timescale 1ns/1ns
module mis_tb_top;
  import mis_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        ce = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        pump_running = 1'b0;
  logic        fault_in = 1'b0;
  logic        want_closed = 1'b0;
  logic        chatter = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, contact_closed, stop_request;
  logic        alarm_event, shutdown_event, fault_clear, irq;
  logic [31:0] rv;
  int          errors = 0;
  int          checks = 0;
  int          cycles = 0;

  always #4 hclk = ~hclk;

  mis_field u_field (.hclk(hclk), .want_closed(want_closed), .chatter(chatter), .contact_closed(contact_closed));

  mis_top #(.TICK_CYCLES(4)) dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .contact_closed(contact_closed),
    .pump_running(pump_running), .fault_in(fault_in), .stop_request(stop_request),
    .alarm_event(alarm_event), .shutdown_event(shutdown_event), .fault_clear(fault_clear), .irq(irq));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", n, exp, got);
    end
  endtask : chk

  task automatic bchk(input string n, input logic got, input logic exp);
    chk(n, {31'h0, got}, {31'h0, exp});
  endtask : bchk

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc

  // read data is taken at the edge that ends the data phase
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(n, rv, e);
  endtask : rdchk

  task automatic drv(input logic p, input logic c);
    @(posedge hclk);
    pump_running <= p;
    want_closed <= c;
  endtask : drv

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_regs;
    rdchk("qual", MIS_OFS_QUAL, {16'h0, MIS_QUAL_RST});
    rdchk("start", MIS_OFS_START, {16'h0, MIS_START_RST});
    rdchk("detect", MIS_OFS_DETECT, {16'h0, MIS_DETECT_RST});
    rdchk("restart", MIS_OFS_RESTART, {16'h0, MIS_RESTART_RST});
    rdchk("ctrl", MIS_OFS_CTRL, {27'h0, MIS_CTRL_RST});
    wr(8'h40, 32'hffffffff);
    rdchk("unmapped", 8'h40, 32'h0);
    rdchk("ctrl kept", MIS_OFS_CTRL, {27'h0, MIS_CTRL_RST});
    wr(MIS_OFS_IRQ_MASK, 32'h2);
    rdchk("mask", MIS_OFS_IRQ_MASK, 32'h2);
  endtask : s_regs

  task automatic s_qual;
    wr(MIS_OFS_QUAL, 32'h3);
    wr(MIS_OFS_CTRL, 32'h1);
    drv(1'b0, 1'b1);
    rdchk("qual early", MIS_OFS_STATUS, 32'h0);
    cyc(16);
    rdchk("qual closed", MIS_OFS_STATUS, 32'h1);
    chatter <= 1'b1;
    cyc(24);
    rdchk("qual chatter", MIS_OFS_STATUS, 32'h0);
    chatter <= 1'b0;
    drv(1'b0, 1'b0);
    cyc(16);
    rdchk("qual open pol2", MIS_OFS_STATUS, 32'h0);
    wr(MIS_OFS_CTRL, 32'h0);
    cyc(16);
    rdchk("qual open pol1", MIS_OFS_STATUS, 32'h1);
    wr(MIS_OFS_QUAL, 32'h0);
  endtask : s_qual

  task automatic s_react;
    for (int r = 0; r < 3; r++) begin
      wr(MIS_OFS_CTRL, {29'h0, r[1:0], 1'b0});
      drv(1'b0, 1'b0);
      cyc(20);
      #1;
      bchk("idle alarm", alarm_event, 1'b0);
      bchk("idle shut", shutdown_event, 1'b0);
      drv(1'b1, 1'b0);
      cyc(20);
      #1;
      bchk("alarm", alarm_event, r == 1);
      bchk("shut", shutdown_event, r == 2);
      bchk("stop", stop_request, r == 2);
      drv(1'b0, 1'b1);
      wr(MIS_OFS_CMD, 32'h1);
    end
  endtask : s_react

  task automatic s_restart;
    wr(MIS_OFS_CTRL, 32'h4);
    drv(1'b1, 1'b0);
    cyc(20);
    drv(1'b0, 1'b1);
    cyc(30);
    #1;
    bchk("held shut", shutdown_event, 1'b1);
    bchk("irq", irq, 1'b1);
    rdchk("irq st", MIS_OFS_IRQ_ST, 32'h7);
    wr(MIS_OFS_CMD, 32'h1);
    cyc(2);
    #1;
    bchk("manual clear", shutdown_event, 1'b0);
    wr(MIS_OFS_IRQ_ST, 32'h7);
    cyc(2);
    #1;
    bchk("irq clear", irq, 1'b0);
    rdchk("irq st clr", MIS_OFS_IRQ_ST, 32'h0);
    wr(MIS_OFS_RESTART, 32'h5);
    wr(MIS_OFS_CTRL, 32'hc);
    drv(1'b1, 1'b0);
    cyc(12);
    drv(1'b0, 1'b1);
    #1;
    bchk("timed held", shutdown_event, 1'b1);
    cyc(30);
    #1;
    bchk("timed clear", shutdown_event, 1'b0);
  endtask : s_restart

  task automatic s_rfunc;
    wr(MIS_OFS_CTRL, 32'h4);
    drv(1'b1, 1'b0);
    cyc(20);
    drv(1'b0, 1'b1);
    wr(MIS_OFS_CTRL, 32'h10);
    fault_in <= 1'b1;
    drv(1'b0, 1'b0);
    cyc(3);
    #1;
    bchk("reset input", shutdown_event, 1'b0);
    bchk("fault clear", fault_clear, 1'b1);
    drv(1'b0, 1'b1);
    fault_in <= 1'b0;
  endtask : s_rfunc

  task automatic s_rearm;
    wr(MIS_OFS_START, 32'h5);
    wr(MIS_OFS_DETECT, 32'h3);
    wr(MIS_OFS_CTRL, 32'h2);
    drv(1'b1, 1'b0);
    cyc(12);
    #1;
    bchk("arming", alarm_event, 1'b0);
    cyc(24);
    #1;
    bchk("armed alarm", alarm_event, 1'b1);
    drv(1'b1, 1'b1);
    drv(1'b1, 1'b0);
    cyc(4);
    drv(1'b1, 1'b1);
    cyc(16);
    #1;
    bchk("short pulse", alarm_event, 1'b0);
    drv(1'b1, 1'b0);
    cyc(16);
    #1;
    bchk("bypass", alarm_event, 1'b1);
    @(posedge hclk);
    ce <= 1'b0;
    drv(1'b1, 1'b1);
    cyc(6);
    #1;
    bchk("frozen", alarm_event, 1'b1);
    @(posedge hclk);
    ce <= 1'b1;
    drv(1'b0, 1'b1);
  endtask : s_rearm

  initial begin
    cyc(2);
    hresetn <= 1'b1;
    s_regs();
    s_qual();
    s_react();
    s_restart();
    s_rfunc();
    s_rearm();
    wrap_up();
  end
endmodule : mis_tb_top
